/* verilog/chg_pkg.sv */
// Package for the charger control and status register block.
// Assumes: a 50 MHz system clock and an APB register bus with 32-bit data.
package chg_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [9:0] CHG_IDX_PROTECT_BOOST = 10'h006;
    localparam logic [9:0] CHG_IDX_SWITCH_TRACK = 10'h007;
    localparam logic [9:0] CHG_IDX_STATUS = 10'h008;
    localparam logic [9:0] CHG_IDX_AUX_CTRL = 10'h010;
    localparam int CHG_ADDR_W = 12;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CHG_RST_PROTECT_BOOST = 8'he6;
    localparam logic [7:0] CHG_RST_SWITCH_TRACK = 8'h4c;
    localparam logic [1:0] CHG_RST_OFFSET_SEL = 2'h0;

    // ------------------------------------------------------------------
    // Field positions, first control register
    // ------------------------------------------------------------------
    localparam int CHG_OVP_LSB = 6;
    localparam int CHG_BOOST_LSB = 4;
    localparam int CHG_VREG_CODE_LSB = 0;

    // ------------------------------------------------------------------
    // Field positions, second control register
    // ------------------------------------------------------------------
    localparam int CHG_DET_BIT = 7;
    localparam int CHG_HALF_BIT = 6;
    localparam int CHG_SWOFF_BIT = 5;
    localparam int CHG_WARM_BIT = 4;
    localparam int CHG_DLY_BIT = 3;
    localparam int CHG_SWRST_BIT = 2;
    localparam int CHG_TRACK_LSB = 0;

    // Bits of the second control register that a watchdog expiry restores
    localparam logic [7:0] CHG_WDOG_MASK = 8'hd4;

    // ------------------------------------------------------------------
    // Field positions, auxiliary control register
    // ------------------------------------------------------------------
    localparam int CHG_AUX_REGRST_BIT = 0;
    localparam int CHG_AUX_OFFSET_LSB = 1;

    // ------------------------------------------------------------------
    // Voltage figures in millivolts
    // ------------------------------------------------------------------
    localparam logic [13:0] CHG_OFFSET_0_MV = 14'd3900;
    localparam logic [13:0] CHG_OFFSET_1_MV = 14'd5900;
    localparam logic [13:0] CHG_OFFSET_2_MV = 14'd7500;
    localparam logic [13:0] CHG_OFFSET_3_MV = 14'd10500;
    localparam logic [13:0] CHG_VREG_STEP_MV = 14'd100;
    localparam logic [13:0] CHG_TRACK_1_MV = 14'd200;
    localparam logic [13:0] CHG_TRACK_2_MV = 14'd250;
    localparam logic [13:0] CHG_TRACK_3_MV = 14'd300;
    localparam logic [13:0] CHG_WARM_LIMIT_MV = 14'd4100;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CHG_CLK_HZ = 50_000_000;
    localparam longint CHG_SHIP_DLY_S = 12;
    localparam int CHG_SHIP_DLY_CYC = int'(CHG_SHIP_DLY_S * CHG_CLK_HZ);
    localparam int CHG_CNT_W = 30;

    // Battery switch states
    typedef enum logic [1:0] {
        CHG_SW_ON,
        CHG_SW_WAIT,
        CHG_SW_OFF
    } chg_sw_e;

    // Synchronised status inputs
    localparam int CHG_STAT_W = 13;

endpackage : chg_pkg

/* verilog/chg_sync_if.sv */
// Interface carrying raw and synchronised status bits.
// Assumes: one clock for both ends.
interface chg_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport user (output raw, input sync);
    modport sync_end (input raw, output sync);
endinterface : chg_sync_if

/* verilog/chg_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous level inputs.
// Assumes: the bits are independent levels; no bundle coherence is needed.
module chg_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst,
    chg_sync_if.sync_end port
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } chg_sync_s;

    chg_sync_s s_q;
    chg_sync_s s_d;

    // First stage feeds only the second stage
    always_comb begin
        s_d.meta = port.raw;
        s_d.sync = s_q.meta;
    end

    // Register both stages
    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign port.sync = s_q.sync;

endmodule : chg_sync

/* verilog/chg_regs.sv */
// Charger control and status registers behind an APB slave.
// Assumes: status inputs come from analog pins (synchronised here); the
// battery voltage, charge voltage and watchdog expiry come from logic on
// the same clock.
//
// Contract
// - Control bits 7:6 pick input over-voltage level; reset is 14V code.
// - Control bits 5:4 pick boost output target; reset is 5.15V code.
// - Input regulation threshold is offset plus 100mV times code; code resets 0110.
// - Offset select gives 3.9V, 5.9V, 7.5V or 10.5V offset.
// - Writing 1 with input present forces current detection; clears when done.
// - Half-rate bit slows safety timer during DPM, cool or thermal regulation.
// - Switch-off bit turns battery switch off, immediately or after ship delay.
// - Delay bit: 0 turns off at once, 1 after twelve seconds.
// - Warm band charges to min of 4.1V and programmed unless bit set.
// - Bit 2 enables switch-based full system reset; reset value one.
// - Tracking adds 200/250/300mV to battery; larger of both is used.
// - Status bits 7:5 report the input source type code.
// - Pin-selected variant reports its source codes in the same field.
// - Status bits 4:3 report the charge phase.
// - Status bit 2 reports input power good.
// - Status bit 1 reports thermal regulation active.
// - Status bit 0 reports minimum system regulation active.
// - Status register is read-only and reflects live conditions.
// - Register reset restores defaults, resets safety timer, then self-clears.
//
// Our own choice: the APB slave port.

module chg_regs
    import chg_pkg::*;
#(
    parameter int SHIP_DLY_CYC = chg_pkg::CHG_SHIP_DLY_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,

    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [chg_pkg::CHG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Asynchronous status inputs
    input wire logic [2:0] source_type_in,
    input wire logic [1:0] charge_phase_in,
    input wire logic power_good_in,
    input wire logic thermal_reg_in,
    input wire logic min_system_reg_in,
    input wire logic vbus_present_in,
    input wire logic detect_done_in,
    input wire logic dpm_active_in,
    input wire logic cool_band_in,
    input wire logic warm_band_in,

    // Same-clock inputs
    input wire logic watchdog_expired,
    input wire logic [13:0] battery_mv,
    input wire logic [13:0] programmed_charge_mv,

    // Control outputs
    output logic [1:0] input_overvolt_level,
    output logic [1:0] boost_output_target,
    output logic [13:0] input_reg_threshold_mv,
    output logic [13:0] charge_target_mv,
    output logic force_current_detect,
    output logic safety_timer_half_rate,
    output logic safety_timer_reset,
    output logic battery_switch_on,
    output logic switch_system_reset_enable
);
    import chg_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        // Fields
        logic [7:0] ctl_a;
        logic [7:0] ctl_b;
        logic [1:0] offset_sel;
        logic reg_reset;
        logic tmr_reset;

        // Bus answer
        logic pready;
        logic pslverr;
        logic [31:0] prdata;

        // Switch
        chg_sw_e sw;
        logic [CHG_CNT_W-1:0] cnt;

        // Outputs
        logic sw_on;
        logic half_rate;
        logic [13:0] vin_reg_mv;
        logic [13:0] chg_mv;
    } chg_state_s;

    chg_state_s s_q;
    chg_state_s s_d;

    // ------------------------------------------------------------------
    // Status input synchronisers
    // ------------------------------------------------------------------
    chg_sync_if #(.W(CHG_STAT_W)) stat_if ();

    // Pins in bit order
    assign stat_if.raw = {source_type_in, charge_phase_in, power_good_in,
                          thermal_reg_in, min_system_reg_in, vbus_present_in,
                          detect_done_in, dpm_active_in, cool_band_in,
                          warm_band_in};

    // Two flops per pin
    chg_sync #(.W(CHG_STAT_W)) u_sync (
        .clock(clock),
        .rst(rst),
        .port(stat_if.sync_end)
    );

    logic [7:0] status_byte;
    logic vbus_s;
    logic done_s;
    logic dpm_s;
    logic cool_s;
    logic warm_s;

    // Live status byte and internal condition levels
    assign status_byte = stat_if.sync[12:5];

    // Condition levels
    assign vbus_s = stat_if.sync[4];
    assign done_s = stat_if.sync[3];
    assign dpm_s = stat_if.sync[2];
    assign cool_s = stat_if.sync[1];
    assign warm_s = stat_if.sync[0];

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [9:0] idx;
    logic aligned;
    logic access;
    logic wr_en;
    logic mapped;

    // Current transfer
    assign idx = paddr[CHG_ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign access = psel && penable && !s_q.pready;
    // Write on answer edge
    assign wr_en = psel && penable && s_q.pready && pwrite && pstrb[0] && aligned;
    assign mapped = aligned && ((idx == CHG_IDX_PROTECT_BOOST)
                    || (idx == CHG_IDX_SWITCH_TRACK)
                    || (idx == CHG_IDX_STATUS)
                    || (idx == CHG_IDX_AUX_CTRL));

    // ------------------------------------------------------------------
    // Derived voltages
    // ------------------------------------------------------------------
    logic [13:0] offset_mv;
    logic [13:0] code_mv;
    logic [13:0] track_mv;
    logic [13:0] reg_mv;

    // Offset, code step and tracking add-on
    always_comb begin
        case (s_q.offset_sel)
            2'h0: offset_mv = CHG_OFFSET_0_MV;
            2'h1: offset_mv = CHG_OFFSET_1_MV;
            2'h2: offset_mv = CHG_OFFSET_2_MV;
            default: offset_mv = CHG_OFFSET_3_MV;
        endcase

        // Register code step
        code_mv = 14'(CHG_VREG_STEP_MV * 14'(s_q.ctl_a[CHG_VREG_CODE_LSB +: 4]));
        reg_mv = 14'(offset_mv + code_mv);

        // Battery tracking
        case (s_q.ctl_b[CHG_TRACK_LSB +: 2])
            2'h1: track_mv = 14'(battery_mv + CHG_TRACK_1_MV);
            2'h2: track_mv = 14'(battery_mv + CHG_TRACK_2_MV);
            2'h3: track_mv = 14'(battery_mv + CHG_TRACK_3_MV);
            default: track_mv = 14'h0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        // Hold by default
        s_d = s_q;
        s_d.tmr_reset = 1'b0;

        // One-wait-state slave: pready rises for one cycle
        s_d.pready = access;
        s_d.pslverr = access && !mapped;

        // Read data
        if (access && !pwrite) begin
            case (mapped ? idx : 10'h3ff)
                CHG_IDX_PROTECT_BOOST: s_d.prdata = {24'h0, s_q.ctl_a};
                CHG_IDX_SWITCH_TRACK: s_d.prdata = {24'h0, s_q.ctl_b};
                CHG_IDX_STATUS: s_d.prdata = {24'h0, status_byte};
                CHG_IDX_AUX_CTRL: s_d.prdata = {29'h0, s_q.offset_sel, s_q.reg_reset};
                default: s_d.prdata = 32'h0;
            endcase
        end else if (access) begin
            s_d.prdata = 32'h0;
        end

        // Hardware ends a forced detection when it completes
        if (done_s) begin
            s_d.ctl_b[CHG_DET_BIT] = 1'b0;
        end

        // Host writes; the status register ignores them
        if (wr_en) begin
            case (idx)
                CHG_IDX_PROTECT_BOOST: s_d.ctl_a = pwdata[7:0];

                CHG_IDX_SWITCH_TRACK: begin
                    s_d.ctl_b = pwdata[7:0];
                    // Set wins over the done clear; needs input present
                    s_d.ctl_b[CHG_DET_BIT] = pwdata[CHG_DET_BIT] && vbus_s;
                end

                CHG_IDX_AUX_CTRL: begin
                    s_d.offset_sel = pwdata[CHG_AUX_OFFSET_LSB +: 2];
                    s_d.reg_reset = pwdata[CHG_AUX_REGRST_BIT];
                end

                default: s_d.reg_reset = s_q.reg_reset;
            endcase
        end

        // Watchdog expiry restores its subset of the second register
        if (watchdog_expired) begin
            s_d.ctl_b = (s_d.ctl_b & ~CHG_WDOG_MASK)
                        | (CHG_RST_SWITCH_TRACK & CHG_WDOG_MASK);
        end

        // Register reset: defaults, safety timer reset, self clear
        if (s_q.reg_reset) begin
            s_d.ctl_a = CHG_RST_PROTECT_BOOST;
            s_d.ctl_b = CHG_RST_SWITCH_TRACK;
            s_d.offset_sel = CHG_RST_OFFSET_SEL;
            s_d.reg_reset = 1'b0;
            s_d.tmr_reset = 1'b1;
        end

        // Battery switch sequencing
        case (s_q.sw)
            // Switch closed
            CHG_SW_ON: begin
                s_d.cnt = '0;
                if (s_q.ctl_b[CHG_SWOFF_BIT]) begin
                    s_d.sw = s_q.ctl_b[CHG_DLY_BIT] ? CHG_SW_WAIT : CHG_SW_OFF;
                end
            end

            // Ship delay
            CHG_SW_WAIT: begin
                if (!s_q.ctl_b[CHG_SWOFF_BIT]) begin
                    s_d.sw = CHG_SW_ON;
                end else if (s_q.cnt == CHG_CNT_W'(SHIP_DLY_CYC - 1)) begin
                    s_d.sw = CHG_SW_OFF;
                end else begin
                    s_d.cnt = CHG_CNT_W'(s_q.cnt + 1'b1);
                end
            end

            // Switch open
            CHG_SW_OFF: begin
                if (!s_q.ctl_b[CHG_SWOFF_BIT]) begin
                    s_d.sw = CHG_SW_ON;
                end
            end

            default: s_d.sw = CHG_SW_ON;
        endcase

        s_d.sw_on = (s_d.sw != CHG_SW_OFF);

        // Half-rate safety timer during DPM, cool band or thermal regulation
        s_d.half_rate = s_q.ctl_b[CHG_HALF_BIT]
                        && (dpm_s || cool_s || status_byte[1]);

        // Input regulation: larger of register threshold and tracking
        s_d.vin_reg_mv = (track_mv > reg_mv) ? track_mv : reg_mv;

        // Warm band charge voltage
        if (warm_s && !s_q.ctl_b[CHG_WARM_BIT]) begin
            s_d.chg_mv = (programmed_charge_mv < CHG_WARM_LIMIT_MV)
                         ? programmed_charge_mv : CHG_WARM_LIMIT_MV;
        end else begin
            s_d.chg_mv = programmed_charge_mv;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
            // Defaults over zero
            s_q.ctl_a <= CHG_RST_PROTECT_BOOST;
            s_q.ctl_b <= CHG_RST_SWITCH_TRACK;
            s_q.offset_sel <= CHG_RST_OFFSET_SEL;
            s_q.sw <= CHG_SW_ON;
            s_q.sw_on <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------------
    // Bus answer
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;

    // Register fields
    assign input_overvolt_level = s_q.ctl_a[CHG_OVP_LSB +: 2];
    assign boost_output_target = s_q.ctl_a[CHG_BOOST_LSB +: 2];

    // Derived levels
    assign input_reg_threshold_mv = s_q.vin_reg_mv;
    assign charge_target_mv = s_q.chg_mv;

    // Detect, timer, switch
    assign force_current_detect = s_q.ctl_b[CHG_DET_BIT];
    assign safety_timer_half_rate = s_q.half_rate;
    assign safety_timer_reset = s_q.tmr_reset;
    assign battery_switch_on = s_q.sw_on;
    assign switch_system_reset_enable = s_q.ctl_b[CHG_SWRST_BIT];

endmodule : chg_regs

/* test/chg_regs_monitor.sv */
// Checker for the charger register block, watching top-level ports only.
// Assumes: a single clock, synchronous active-high reset, bound at the foot.
module chg_regs_monitor #(
    parameter int SHIP_DLY_CYC = 20
) (
    input logic clock,
    input logic rst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [chg_pkg::CHG_ADDR_W-1:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic [13:0] programmed_charge_mv,
    input logic [1:0] input_overvolt_level,
    input logic [1:0] boost_output_target,
    input logic [13:0] input_reg_threshold_mv,
    input logic [13:0] charge_target_mv,
    input logic force_current_detect,
    input logic safety_timer_reset,
    input logic battery_switch_on
);
    timeunit 1ns;
    timeprecision 1ps;
    import chg_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // -------------------------------------------------------------
    // Completed transfers
    // -------------------------------------------------------------
    logic done;
    logic rd_ok;
    logic wr_sw;
    assign done = psel && penable && pready;
    assign rd_ok = done && !pwrite && !pslverr;
    assign wr_sw = done && pwrite && pstrb[0] && paddr == 12'h01c;
    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    chk_ovp_readback: assert property (rd_ok && paddr == 12'h018 |->
        prdata[7:6] == $past(input_overvolt_level)) else $error("overvolt field mismatch");
    chk_boost_readback: assert property (rd_ok && paddr == 12'h018 |->
        prdata[5:4] == $past(boost_output_target)) else $error("boost field mismatch");
    chk_detect_readback: assert property (rd_ok && paddr == 12'h01c |->
        prdata[7] == $past(force_current_detect)) else $error("detect bit mismatch");
    chk_thresh_floor: assert property (!$past(rst) |->
        input_reg_threshold_mv >= 14'd3900) else $error("threshold below lowest offset");
    chk_warm_pass: assert property (
        (programmed_charge_mv <= 14'd4100 && $stable(programmed_charge_mv)) [*3] |=>
        charge_target_mv == $past(programmed_charge_mv)) else $error("charge target wrong");
    chk_status_noerr: assert property (done && paddr == 12'h020 |-> !pslverr)
        else $error("status access flagged as error");
    chk_switch_fast: assert property (wr_sw && pwdata[5] && !pwdata[3] |->
        ##[1:4] !battery_switch_on) else $error("switch not off at once");
    chk_switch_allow: assert property (wr_sw && !pwdata[5] |->
        ##[1:4] battery_switch_on) else $error("switch not back on");
    // Needs a ship delay of at least eight cycles
    chk_switch_hold: assert property (wr_sw && pwdata[5] && pwdata[3] && battery_switch_on
        && SHIP_DLY_CYC >= 8 |=> battery_switch_on [*8]) else $error("switch off too early");
    chk_regrst_pulse: assert property (done && pwrite && pstrb[0] && paddr == 12'h040
        && pwdata[0] |-> ##[1:3] safety_timer_reset) else $error("no timer reset pulse");
    chk_regrst_single: assert property (safety_timer_reset |=> !safety_timer_reset)
        else $error("timer reset pulse too long");
    cover property (wr_sw && pwdata[5]);
    cover property (safety_timer_reset);
    cover property (rd_ok && paddr == 12'h020);
endmodule : chg_regs_monitor

bind chg_regs chg_regs_monitor #(.SHIP_DLY_CYC(SHIP_DLY_CYC)) u_mon (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .programmed_charge_mv(programmed_charge_mv), .input_overvolt_level(input_overvolt_level),
    .boost_output_target(boost_output_target), .input_reg_threshold_mv(input_reg_threshold_mv),
    .charge_target_mv(charge_target_mv), .force_current_detect(force_current_detect),
    .safety_timer_reset(safety_timer_reset), .battery_switch_on(battery_switch_on));

/* test/chg_apb_host.sv */
// Host processor model: an APB master driven by task calls.
// Assumes: the slave answers with pready; the bench bounds any hang.
module chg_apb_host (
    input logic clock,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input logic pready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
    end
    // Setup, then access held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a; // Released lines do not keep their last value
        pwdata <= ~d;
    endtask : xfer
endmodule : chg_apb_host

/* test/test_charger_ctrl_status_regs.sv */
// Self-checking bench for the charger control and status registers.
// Assumes: a host model drives APB; reads are checked from a queue.
module test_charger_ctrl_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] src;
    logic [1:0] phase, ovp, boost;
    logic pg, th, ms, vbus, dn, dpm, cool, warm, wdog, fcd, half, str, swon, sre;
    logic [13:0] bat, prog, thr, tgt, b;
    logic [7:0] v, s;
    logic [32:0] exp_q[$];
    int fail_count, num_checks, cycles;

    chg_apb_host host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));
    chg_regs #(.SHIP_DLY_CYC(20)) dut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .source_type_in(src),
        .charge_phase_in(phase), .power_good_in(pg), .thermal_reg_in(th),
        .min_system_reg_in(ms), .vbus_present_in(vbus), .detect_done_in(dn),
        .dpm_active_in(dpm), .cool_band_in(cool), .warm_band_in(warm),
        .watchdog_expired(wdog), .battery_mv(bat), .programmed_charge_mv(prog),
        .input_overvolt_level(ovp), .boost_output_target(boost),
        .input_reg_threshold_mv(thr), .charge_target_mv(tgt), .force_current_detect(fcd),
        .safety_timer_half_rate(half), .safety_timer_reset(str), .battery_switch_on(swon),
        .switch_system_reset_enable(sre));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 32'h0);
    endtask : rd
    // Offset plus code steps, or the tracking figure if larger
    function automatic logic [13:0] thr_exp(input logic [1:0] os, input logic [3:0] n,
        input logic [1:0] t, input logic [13:0] bv);
        logic [13:0] base, trk;
        base = os == 0 ? 14'd3900 : os == 1 ? 14'd5900 : os == 2 ? 14'd7500 : 14'd10500;
        base = base + 14'd100 * n;
        trk = t == 0 ? 14'd0 : bv + (t == 1 ? 14'd200 : t == 2 ? 14'd250 : 14'd300);
        return trk > base ? trk : base;
    endfunction : thr_exp
    // Read watcher and hang limit
    always @(posedge clock) begin
        cycles++;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h11b8));
        rst = 1'b1;
        {src, phase, pg, th, ms, vbus, dn, dpm, cool, warm, wdog} = '0;
        bat = 14'd0;
        prog = 14'd0;
        cyc(6);
        rst <= 1'b0;
        cyc(3);
        rd(12'h018, 33'h0e6);
        rd(12'h01c, 33'h04c);
        check(33'({ovp, boost, sre, swon}), 33'h3b);
        check(33'(thr), 33'd4500);
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom);
            b = 14'd3000 + 14'($urandom % 7000);
            bat <= b;
            wr(12'h040, {5'h0, i[3:2], 1'b0});
            wr(12'h018, v);
            wr(12'h01c, {6'h13, i[1:0]});
            cyc(3);
            check(33'(thr), 33'(thr_exp(i[3:2], v[3:0], i[1:0], b)));
            check(33'({ovp, boost}), 33'(v[7:4]));
            rd(12'h018, {25'h0, v});
        end
        for (int i = 0; i < 8; i++) begin
            s = {i[2:0], 5'($urandom)};
            {src, phase, pg, th, ms} <= s;
            cyc(4);
            rd(12'h020, {25'h0, s});
            wr(12'h020, ~s);
            rd(12'h020, {25'h0, s});
        end
        {src, phase, pg, th, ms} <= 8'h0;
        rd(12'h030, {1'b1, 32'h0});
        rd(12'h01a, {1'b1, 32'h0});
        wr(12'h01c, 8'hcc);
        rd(12'h01c, 33'h04c);
        vbus <= 1'b1;
        cyc(4);
        wr(12'h01c, 8'hcc);
        rd(12'h01c, 33'h0cc);
        check(33'(fcd), 33'd1);
        dn <= 1'b1;
        cyc(4);
        rd(12'h01c, 33'h04c);
        dn <= 1'b0;
        dpm <= 1'b1;
        cyc(4);
        check(33'(half), 33'd1);
        wr(12'h01c, 8'h0c);
        cyc(3);
        check(33'(half), 33'd0);
        dpm <= 1'b0;
        warm <= 1'b1;
        prog <= 14'd4200;
        wr(12'h01c, 8'h4c);
        cyc(4);
        check(33'(tgt), 33'd4100);
        wr(12'h01c, 8'h5c);
        cyc(3);
        check(33'(tgt), 33'd4200);
        warm <= 1'b0;
        wr(12'h01c, 8'h64);
        cyc(3);
        check(33'(swon), 33'd0);
        wr(12'h01c, 8'h44);
        cyc(3);
        check(33'(swon), 33'd1);
        wr(12'h01c, 8'h6c);
        cyc(8);
        check(33'(swon), 33'd1);
        cyc(20);
        check(33'(swon), 33'd0);
        wr(12'h01c, 8'h13);
        wdog <= 1'b1;
        cyc(1);
        wdog <= 1'b0;
        rd(12'h01c, 33'h047);
        rd(12'h018, {25'h0, v});
        bat <= 14'd0;
        wr(12'h040, 8'h01);
        cyc(3);
        rd(12'h018, 33'h0e6);
        rd(12'h01c, 33'h04c);
        rd(12'h040, 33'h000);
        check(33'(thr), 33'd4500);
        cyc(2);
        final_report();
    end
endmodule : test_charger_ctrl_status_regs
